// [rtl/mpp_cfg.svh]
// constants of the multimode printer port: offsets, bit positions, resets
// assumes the includer uses them as plain integer or sized values
`ifndef MPP_CFG_SVH
`define MPP_CFG_SVH
// register offsets from the port base
`define MPP_OFS_DATA   11'h000
`define MPP_OFS_STAT   11'h001
`define MPP_OFS_CTL    11'h002
`define MPP_OFS_EADDR  11'h003
`define MPP_OFS_EDATA0 11'h004
`define MPP_OFS_EDATA3 11'h007
`define MPP_OFS_FIFO   11'h400
`define MPP_OFS_CFGB   11'h401
`define MPP_OFS_ECR    11'h402
// control register bits
`define MPP_CTL_DIR    5
`define MPP_CTL_ACK_INTERRUPT_ENABLE   4
`define MPP_CTL_SELECT_IN_CONTROL   3
`define MPP_CTL_INIT   2
`define MPP_CTL_AFD    1
`define MPP_CTL_STB    0
// extended control register bits
`define MPP_ECR_MODE   7:5
`define MPP_ECR_CTL    4:2
`define MPP_ECR_FULL   1
`define MPP_ECR_EMPTY  0
`define MPP_ECR_SVC    2
`define MPP_ECR_DMA_TRANSFER_ENABLE  3
// reset values
`define MPP_DATA_RST   8'h00
`define MPP_CTL_RST    6'h00
`define MPP_ECR_RST    3'h1
`define MPP_MODE_RST   3'h0
// fixed read values
`define MPP_CFGA_VAL   8'h10
`define MPP_TOP_ONES   2'h3
`define MPP_LOW_ONES   2'h3
// enhanced cycle time-out and fifo depth
`define MPP_TMO_MS     10
`define MPP_CLK_KHZ    40000
`define MPP_FIFO_DEPTH 16
`endif

// [rtl/mpp_pkg.sv]
// types of the multimode printer port
// assumes mpp_cfg.svh holds every number except the mode encodings given here
`default_nettype none
package mpp_pkg;
	// port modes as held in the extended control register
	typedef enum logic [2:0] {
		MPP_M_STD = 3'h0, MPP_M_BIDIR = 3'h1, MPP_M_COMPAT_DATA_FIFO = 3'h2, MPP_M_ECP = 3'h3,
		MPP_M_RSV4 = 3'h4, MPP_M_RSV5 = 3'h5, MPP_M_TEST = 3'h6, MPP_M_CONF = 3'h7
	} mpp_mode_t;
	typedef enum logic [1:0] {MPP_E_IDLE, MPP_E_STRB, MPP_E_HOLD} mpp_epp_st_t;
	typedef enum logic [1:0] {MPP_F_IDLE, MPP_F_SET, MPP_F_STRB, MPP_F_REL} mpp_fwd_st_t;
	typedef enum logic [1:0] {MPP_R_IDLE, MPP_R_WAIT, MPP_R_ACK, MPP_R_PROC} mpp_rev_st_t;
endpackage : mpp_pkg
`default_nettype wire

// [rtl/mpp_fifo_mem.sv]
// storage of the transfer fifo, registered read with write bypass
// assumes one writer and one reader in the clk domain
`default_nettype none
module mpp_fifo_mem #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0]            rdata;
	} mpp_mem_st_t;
	mpp_mem_st_t s_q, s_d;

	// write then read, new word passed straight through on a hit
	always_comb begin
		s_d = s_q;
		if (wr_en) begin
			s_d.mem[wr_addr] = wr_data;
		end
		s_d.rdata = s_d.mem[rd_addr];
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data = s_q.rdata;
endmodule : mpp_fifo_mem
`default_nettype wire

// [rtl/mpp_port.sv]
// multimode printer port: compatible, enhanced handshake and fifo modes
// assumes io strobes are synchronous to clk and base decode arrives as io_cs
`include "mpp_cfg.svh"
`default_nettype none
module mpp_port #(
	parameter int TIMEOUT_CYC = `MPP_TMO_MS * `MPP_CLK_KHZ,
	parameter int DEPTH       = `MPP_FIFO_DEPTH
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        enhanced_mode,
	input  wire logic        io_cs,
	input  wire logic [10:0] io_addr,
	input  wire logic        io_rd,
	input  wire logic        io_wr,
	input  wire logic [7:0]  io_wdata,
	output logic      [7:0]  io_rdata,
	output logic             io_chrdy,
	output logic             host_irq,
	output logic             dma_req,
	input  wire logic        dma_ack,
	input  wire logic [7:0]  pd_in,
	output logic      [7:0]  pd_out,
	output logic             pd_oe,
	input  wire logic        busy,
	input  wire logic        ack_n,
	input  wire logic        paper_end,
	input  wire logic        printer_online,
	input  wire logic        fault_n,
	output logic             strobe_n,
	output logic             auto_feed_n,
	output logic             init_n,
	output logic             select_in_n
);
	import mpp_pkg::*;
	localparam int AW = $clog2(DEPTH);
	localparam int TW = $clog2(TIMEOUT_CYC + 1);
	localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYC - 1);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk_depth
		$error("fifo depth must be a power of two");
	end
	if (TIMEOUT_CYC < 2) begin : g_chk_tmo
		$error("time-out count too small");
	end

	typedef struct packed {
		logic [7:0]    data;
		logic [5:0]    ctl;
		mpp_mode_t     mode;
		logic [2:0]    ecr;
		logic          tmo;
		logic          rd_prev;
		logic          wr_prev;
		logic          ack_prev;
		logic [7:0]    rdata;
		logic          irq;
		mpp_epp_st_t   est;
		logic          e_wr;
		logic          e_addr;
		logic [7:0]    e_byte;
		logic [TW-1:0] tcnt;
		logic [AW:0]   wp;
		logic [AW:0]   rp;
		mpp_fwd_st_t   fst;
		logic [8:0]    f_byte;
		mpp_rev_st_t   rst;
		logic [8:0]    r_byte;
		logic [6:0]    rle_cnt;
		logic          rle_pend;
		logic [7:0]    last;
	} mpp_port_st_t;
	mpp_port_st_t s_q, s_d;

	logic       rd_go, wr_go, hrd, hwr, epp_sel, epp_start, dir, fwd_mode;
	logic       empty, full, push, pop;
	logic [8:0] push_data, head;

	mpp_fifo_mem #(.WIDTH(9), .DEPTH(DEPTH), .AW(AW)) u_mem (
		.clk     (clk),
		.nrst    (nrst),
		.wr_en   (push),
		.wr_addr (s_q.wp[AW-1:0]),
		.wr_data (push_data),
		.rd_addr (s_d.rp[AW-1:0]),
		.rd_data (head)
	);

	// access decode on leading strobe edges
	always_comb begin
		rd_go     = io_rd && !s_q.rd_prev;
		wr_go     = io_wr && !s_q.wr_prev;
		hrd       = rd_go && io_cs;
		hwr       = wr_go && io_cs;
		epp_sel   = enhanced_mode && io_cs && io_addr >= `MPP_OFS_EADDR && io_addr <= `MPP_OFS_EDATA3;
		epp_start = epp_sel && (rd_go || wr_go) && s_q.est == MPP_E_IDLE;
		dir       = s_q.ctl[`MPP_CTL_DIR] && s_q.mode != MPP_M_STD && s_q.mode != MPP_M_COMPAT_DATA_FIFO;
		fwd_mode  = (s_q.mode == MPP_M_COMPAT_DATA_FIFO || s_q.mode == MPP_M_ECP) && !dir;
		empty     = s_q.wp == s_q.rp;
		full      = s_q.wp == {~s_q.rp[AW], s_q.rp[AW-1:0]};
	end

	// main next-state process
	always_comb begin
		s_d       = s_q;
		push      = 1'b0;
		pop       = 1'b0;
		push_data = 9'h000;
		s_d.rd_prev  = io_rd;
		s_d.wr_prev  = io_wr;
		s_d.ack_prev = ack_n;
		s_d.irq      = s_q.ctl[`MPP_CTL_ACK_INTERRUPT_ENABLE] && ack_n && !s_q.ack_prev;

		// host register writes
		if (hwr && !epp_sel) begin
			unique case (io_addr)
				`MPP_OFS_DATA: begin
					if (s_q.mode == MPP_M_ECP && !full) begin
						push      = 1'b1;
						push_data = {1'b1, io_wdata};
					end else begin
						s_d.data = io_wdata;
					end
				end
				`MPP_OFS_CTL: s_d.ctl = io_wdata[5:0];
				`MPP_OFS_FIFO: begin
					if ((fwd_mode || s_q.mode == MPP_M_TEST) && !full) begin
						push      = 1'b1;
						push_data = {1'b0, io_wdata};
					end
				end
				`MPP_OFS_ECR: begin
					s_d.mode = mpp_mode_t'(io_wdata[`MPP_ECR_MODE]);
					s_d.ecr  = io_wdata[`MPP_ECR_CTL];
				end
				default: ; // status write handled below for time-out clear, cfgb writes ignored
			endcase
		end
		// dma writes go straight into the fifo
		if (wr_go && dma_ack && !full && !push) begin
			push      = 1'b1;
			push_data = {1'b0, io_wdata};
		end

		// host register reads, sampled at the read edge
		if (hrd && !epp_sel) begin
			unique case (io_addr)
				`MPP_OFS_DATA: s_d.rdata = dir ? pd_in : s_q.data;
				`MPP_OFS_STAT: s_d.rdata = {~busy, ack_n, paper_end, printer_online, fault_n,
					`MPP_LOW_ONES, enhanced_mode ? s_q.tmo : 1'b1};
				`MPP_OFS_CTL: s_d.rdata = {`MPP_TOP_ONES, s_q.ctl};
				`MPP_OFS_FIFO: begin
					if (s_q.mode == MPP_M_CONF) begin
						s_d.rdata = `MPP_CFGA_VAL;
					end else if (!empty) begin
						pop       = 1'b1;
						s_d.rdata = head[7:0];
						s_d.last  = head[7:0];
					end else begin
						s_d.rdata = s_q.last;
					end
				end
				`MPP_OFS_CFGB: s_d.rdata = (s_q.mode == MPP_M_CONF) ? {1'b0, s_q.irq, 6'h00} : 8'h00;
				`MPP_OFS_ECR: s_d.rdata = {s_q.mode, s_q.ecr, full, empty};
				default: s_d.rdata = 8'h00;
			endcase
		end
		if (rd_go && dma_ack && !empty) begin
			pop       = 1'b1;
			s_d.rdata = head[7:0];
			s_d.last  = head[7:0];
		end

		// time-out flag: write one clears, expiry sets and wins
		if (hwr && io_addr == `MPP_OFS_STAT && io_wdata[0]) begin
			s_d.tmo = 1'b0;
		end

		// enhanced handshake cycles
		unique case (s_q.est)
			MPP_E_IDLE: begin
				if (epp_start) begin
					s_d.est    = MPP_E_STRB;
					s_d.e_wr   = wr_go;
					s_d.e_addr = io_addr == `MPP_OFS_EADDR;
					s_d.e_byte = io_wdata;
					s_d.tcnt   = '0;
				end
			end
			MPP_E_STRB: begin
				s_d.tcnt = s_q.tcnt + 1'b1;
				if (busy) begin
					s_d.est  = MPP_E_HOLD;
					s_d.tcnt = '0;
					if (!s_q.e_wr) begin
						s_d.rdata = pd_in;
					end
				end else if (s_q.tcnt == TMO_LAST) begin
					s_d.est = MPP_E_IDLE;
					s_d.tmo = 1'b1;
				end
			end
			MPP_E_HOLD: begin
				s_d.tcnt = s_q.tcnt + 1'b1;
				if (!busy) begin
					s_d.est = MPP_E_IDLE;
				end else if (s_q.tcnt == TMO_LAST) begin
					s_d.est = MPP_E_IDLE;
					s_d.tmo = 1'b1;
				end
			end
			default: s_d.est = MPP_E_IDLE;
		endcase

		// forward fifo drain toward the peripheral
		unique case (s_q.fst)
			MPP_F_IDLE: begin
				if (fwd_mode && !empty && !busy && !pop) begin
					pop        = 1'b1;
					s_d.f_byte = head;
					s_d.fst    = MPP_F_SET;
				end
			end
			MPP_F_SET: s_d.fst = MPP_F_STRB;
			MPP_F_STRB: begin
				if (busy) begin
					s_d.fst = MPP_F_REL;
				end
			end
			MPP_F_REL: begin
				if (!busy) begin
					s_d.fst = MPP_F_IDLE;
				end
			end
		endcase

		// reverse fill from the peripheral with run-length expansion
		unique case (s_q.rst)
			MPP_R_IDLE: begin
				if (s_q.mode == MPP_M_ECP && dir && !full) begin
					s_d.rst = MPP_R_WAIT;
				end
			end
			MPP_R_WAIT: begin
				if (!ack_n) begin
					s_d.r_byte = {busy, pd_in};
					s_d.rst    = MPP_R_ACK;
				end
			end
			MPP_R_ACK: begin
				if (ack_n) begin
					s_d.rst = MPP_R_PROC;
				end
			end
			MPP_R_PROC: begin
				if (!s_q.r_byte[8]) begin
					if (!s_q.r_byte[7]) begin
						s_d.rle_cnt  = s_q.r_byte[6:0];
						s_d.rle_pend = 1'b1;
					end
					s_d.rst = MPP_R_IDLE;
				end else if (!full && !push) begin
					push      = 1'b1;
					push_data = {1'b0, s_q.r_byte[7:0]};
					if (s_q.rle_pend && s_q.rle_cnt != 7'h00) begin
						s_d.rle_cnt = s_q.rle_cnt - 1'b1;
					end else begin
						s_d.rle_pend = 1'b0;
						s_d.rst      = MPP_R_IDLE;
					end
				end
			end
		endcase

		// pointer update, mode zero empties the fifo
		if (push) begin
			s_d.wp = s_q.wp + 1'b1;
		end
		if (pop) begin
			s_d.rp = s_q.rp + 1'b1;
		end
		if (s_q.mode == MPP_M_STD) begin
			s_d.rp                = s_q.wp;
			s_d.ctl[`MPP_CTL_DIR] = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q      <= '0;
			s_q.data <= `MPP_DATA_RST;
			s_q.ctl  <= `MPP_CTL_RST;
			s_q.mode <= mpp_mode_t'(`MPP_MODE_RST);
			s_q.ecr  <= `MPP_ECR_RST;
			s_q.est  <= MPP_E_IDLE;
			s_q.fst  <= MPP_F_IDLE;
			s_q.rst  <= MPP_R_IDLE;
			s_q.ack_prev <= 1'b1; // ack idles high, so no false edge after reset
		end else begin
			s_q <= s_d;
		end
	end

	// cable pins: hardware owns the strobes only during its own cycles
	always_comb begin
		init_n      = s_q.ctl[`MPP_CTL_INIT];
		strobe_n    = ~s_q.ctl[`MPP_CTL_STB];
		auto_feed_n = ~s_q.ctl[`MPP_CTL_AFD];
		select_in_n = ~s_q.ctl[`MPP_CTL_SELECT_IN_CONTROL];
		pd_out      = s_q.data;
		pd_oe       = !dir;
		if (s_q.est != MPP_E_IDLE) begin
			strobe_n    = !s_q.e_wr;
			select_in_n = !(s_q.est == MPP_E_STRB && s_q.e_addr);
			auto_feed_n = !(s_q.est == MPP_E_STRB && !s_q.e_addr);
			pd_out      = s_q.e_byte;
			pd_oe       = s_q.e_wr;
		end else if (s_q.fst != MPP_F_IDLE) begin
			strobe_n    = s_q.fst != MPP_F_STRB;
			auto_feed_n = !s_q.f_byte[8];
			pd_out      = s_q.f_byte[7:0];
		end else if (s_q.rst == MPP_R_WAIT) begin
			auto_feed_n = 1'b0;
		end else if (s_q.mode == MPP_M_TEST) begin
			pd_out = head[7:0];
		end
	end

	// host side answers
	assign io_chrdy = !(epp_start || s_q.est == MPP_E_STRB);
	assign io_rdata = s_q.rdata;
	assign host_irq = s_q.irq;
	// stored ecr field holds register bits 4:2, so positions are offset by two
	assign dma_req  = s_q.ecr[`MPP_ECR_DMA_TRANSFER_ENABLE - 2] && !s_q.ecr[`MPP_ECR_SVC - 2] &&
		(fwd_mode ? !full : (s_q.mode == MPP_M_ECP && !empty));
endmodule : mpp_port
`default_nettype wire

// [dv/mpp_port_monitor.sv]
// concurrent checks on the printer port pins and host strobes
// assumes one clk domain and the async active-low nrst
`default_nettype none
module mpp_port_monitor #(
	parameter int TIMEOUT_CYC = 50
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic enhanced_mode,
	input wire logic io_cs,
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic io_chrdy,
	input wire logic host_irq,
	input wire logic ack_n,
	input wire logic pd_oe,
	input wire logic busy,
	input wire logic strobe_n,
	input wire logic auto_feed_n,
	input wire logic select_in_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	logic [31:0] lo_q;
	// cycles spent with host ready held low
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) lo_q <= 32'h0;
		else lo_q <= io_chrdy ? 32'h0 : lo_q + 32'h1;
	end
	AST_IRQ_PULSE: assert property (host_irq |=> !host_irq) else $error("irq wider than one cycle");
	AST_IRQ_CAUSE: assert property (host_irq |-> $past(ack_n)) else $error("irq without ack high");
	AST_RDY_FALL: assert property ($fell(io_chrdy) |-> io_cs && (io_rd || io_wr) && enhanced_mode)
		else $error("ready dropped without access");
	AST_RDY_MAX: assert property (lo_q <= 32'(TIMEOUT_CYC + 2)) else $error("cycle not aborted");
	AST_STB_REL: assert property (!io_chrdy && !(select_in_n && auto_feed_n) && busy
		|=> io_chrdy && select_in_n && auto_feed_n) else $error("strobe kept after wait");
	AST_WR_REL: assert property (!busy && $past(busy) && !strobe_n |=> strobe_n)
		else $error("write kept after wait");
	AST_WR_STB: assert property ($past(!io_chrdy) && !io_chrdy && pd_oe |-> !strobe_n)
		else $error("write line idle in write");
	AST_RD_NOWR: assert property (!io_chrdy && !pd_oe |-> strobe_n) else $error("write line in read");
	AST_ONE_STB: assert property ($past(!io_chrdy) && !io_chrdy |-> select_in_n != auto_feed_n)
		else $error("strobe choice wrong");
	// main scenarios reached
	CV_ADDR: cover property (!io_chrdy && !select_in_n);
	CV_DATA: cover property (!io_chrdy && !auto_feed_n && !pd_oe);
	CV_IRQ: cover property (host_irq);
	CV_TMO: cover property (lo_q == 32'(TIMEOUT_CYC));
endmodule : mpp_port_monitor
bind mpp_port mpp_port_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_mon (.clk, .nrst, .enhanced_mode, .io_cs,
	.io_rd, .io_wr, .io_chrdy, .host_irq, .ack_n, .pd_oe, .busy, .strobe_n, .auto_feed_n, .select_in_n);
`default_nettype wire

// [dv/mpp_periph_model.sv]
// enhanced-mode peripheral: answers address and data strobes with wait
// assumes control bits 0, 1, 3 are clear while not muted
`default_nettype none
module mpp_periph_model #(
	parameter logic [7:0] RDV = 8'h96
) (
	input  wire logic       clk,
	input  wire logic       mute,
	input  wire logic       auto_feed_n,
	input  wire logic       select_in_n,
	input  wire logic       pd_oe,
	input  wire logic [7:0] pd_out,
	output logic            busy,
	output logic      [7:0] pd_in,
	output logic      [7:0] seen,
	output logic            kind
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] dly;
	initial begin
		busy = 1'b0;
		pd_in = 8'h00;
		seen = 8'h00;
		kind = 1'b0;
		dly = 2'h0;
	end
	// slow answer; released bus toggles every cycle
	always @(posedge clk) begin
		if (!mute && !(select_in_n && auto_feed_n)) begin
			if (!pd_oe) pd_in <= RDV;
			if (dly == 2'h3) begin
				busy <= 1'b1;
				seen <= pd_out;
				kind <= !select_in_n;
			end else dly <= dly + 2'h1;
		end else begin
			dly <= 2'h0;
			busy <= 1'b0;
			pd_in <= ~pd_in;
		end
	end
endmodule : mpp_periph_model
`default_nettype wire

// [dv/mpp_port_tb.sv]
// register, status, irq, enhanced cycle and time-out tests of the port
// assumes a short time-out parameter and the peripheral model
`default_nettype none
module mpp_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, nrst = 0, enh = 0, io_cs = 0, io_rd = 0, io_wr = 0, mute = 1;
	logic ack_n = 1, paper_end = 0, printer_online = 0, fault_n = 1, dma_ack = 0;
	logic [10:0] io_addr = 11'h0;
	logic [7:0]  io_wdata = 8'h0, got, seen;
	logic [7:0]  io_rdata, pd_in, pd_out;
	logic        io_chrdy, host_irq, dma_req, pd_oe, busy, kind;
	logic        strobe_n, auto_feed_n, init_n, select_in_n;
	int          error_cnt = 0, n_tests = 0, irq_cnt = 0, i;
	mpp_port #(.TIMEOUT_CYC(50)) uut (.clk, .nrst, .enhanced_mode(enh), .io_cs, .io_addr, .io_rd, .io_wr,
		.io_wdata, .io_rdata, .io_chrdy, .host_irq, .dma_req, .dma_ack, .pd_in, .pd_out, .pd_oe,
		.busy, .ack_n, .paper_end, .printer_online, .fault_n, .strobe_n, .auto_feed_n, .init_n, .select_in_n);
	mpp_periph_model u_per (.clk, .mute, .auto_feed_n, .select_in_n, .pd_oe, .pd_out, .busy, .pd_in,
		.seen, .kind);
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) if (host_irq === 1'b1) irq_cnt++;
	task final_report;
		if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	task ck(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : ck
	// one host access, held until ready, read data into got
	task acc(input logic w, input logic [10:0] a, input logic [7:0] d);
		int k;
		repeat (2) @(posedge clk);
		io_cs <= 1;
		io_addr <= a;
		io_wdata <= d;
		if (w) io_wr <= 1;
		else io_rd <= 1;
		@(posedge clk);
		for (k = 0; k < 200; k++) begin
			@(posedge clk);
			if (io_chrdy === 1'b1) break;
		end
		if (k == 200) begin
			error_cnt++;
			$display("[FAIL] %0t ready never returned", $time);
		end
		got = io_rdata;
		io_cs <= 0;
		io_rd <= 0;
		io_wr <= 0;
	endtask : acc
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		final_report();
	end
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1;
		ck(8'({strobe_n, auto_feed_n, init_n, select_in_n, pd_oe}), 8'h1B);
		acc(1, 11'h2, 8'h2A);
		acc(0, 11'h2, 8'h0); ck(got, 8'hCA);
		ck(8'({strobe_n, auto_feed_n, init_n, select_in_n, pd_oe}), 8'h11);
		acc(1, 11'h402, 8'h24);
		acc(0, 11'h402, 8'h0); ck(got, 8'h25);
		acc(1, 11'h2, 8'h25);
		acc(0, 11'h2, 8'h0); ck(got, 8'hE5);
		ck(8'({strobe_n, auto_feed_n, init_n, select_in_n, pd_oe}), 8'h0E);
		ack_n <= 0;
		paper_end <= 1;
		acc(0, 11'h1, 8'h0); ck(got, 8'hAF);
		acc(1, 11'h1, 8'h0);
		printer_online <= 1;
		fault_n <= 0;
		paper_end <= 0;
		acc(0, 11'h1, 8'h0); ck(got, 8'h97);
		acc(1, 11'h2, 8'h14);
		irq_cnt = 0;
		ack_n <= 1;
		repeat (5) @(posedge clk);
		ck(8'(irq_cnt), 8'h01);
		ack_n <= 0;
		acc(1, 11'h2, 8'h04);
		irq_cnt = 0;
		ack_n <= 1;
		repeat (5) @(posedge clk);
		ck(8'(irq_cnt), 8'h00);
		enh <= 1;
		mute <= 0;
		for (i = 3; i < 8; i++) begin
			acc(1, 11'(i), 8'(8'h50 + i)); ck(seen, 8'(8'h50 + i));
			ck(8'(kind), 8'(i == 3));
			acc(0, 11'(i), 8'h0); ck(got, 8'h96);
		end
		mute <= 1;
		acc(1, 11'h3, 8'h11);
		acc(0, 11'h1, 8'h0); ck(got & 8'h07, 8'h07);
		acc(1, 11'h1, 8'h01);
		acc(0, 11'h1, 8'h0); ck(got & 8'h07, 8'h06);
		enh <= 0;
		acc(0, 11'h1, 8'h0); ck(got & 8'h07, 8'h07);
		// fifo mode dma request, with enable set, follows service mask
		acc(1, 11'h402, 8'h48);
		ck(8'(dma_req), 8'h01);
		acc(1, 11'h402, 8'h4C);
		ck(8'(dma_req), 8'h00);
		// test mode: sixteen deep, full flag, head on pins, last byte on empty
		acc(1, 11'h402, 8'hC0);
		for (i = 0; i < 17; i++) begin
			acc(1, 11'h400, 8'(8'h30 + i));
		end
		ck(pd_out, 8'h30);
		acc(0, 11'h402, 8'h0);
		ck(got, 8'hC2);
		for (i = 0; i < 16; i++) begin
			acc(0, 11'h400, 8'h0);
			ck(got, 8'(8'h30 + i));
		end
		acc(0, 11'h400, 8'h0);
		ck(got, 8'h3F);
		acc(0, 11'h402, 8'h0);
		ck(got, 8'hC1);
		dma_ack <= 1;
		acc(1, 11'h7FF, 8'h5A);
		acc(0, 11'h7FF, 8'h0);
		ck(got, 8'h5A);
		dma_ack <= 0;
		// mode zero empties the fifo
		acc(1, 11'h400, 8'h77);
		acc(1, 11'h402, 8'h00);
		acc(0, 11'h402, 8'h0);
		ck(got, 8'h01);
		// configuration mode registers
		acc(1, 11'h402, 8'hE0);
		acc(0, 11'h400, 8'h0);
		ck(got, 8'h10);
		acc(0, 11'h401, 8'h0);
		ck(got, 8'h00);
		final_report();
	end
endmodule : mpp_port_tb
`default_nettype wire
